// ===== inc/plt_consts.vh
// constants for the loopback pattern tester: offsets, fields, codes, resets
`ifndef PLT_CONSTS_VH
`define PLT_CONSTS_VH

// register byte offsets
`define PLT_OFS_CTRL 8'h00
`define PLT_OFS_CFG 8'h04
`define PLT_OFS_STAT 8'h08
`define PLT_OFS_DET 8'h0C
`define PLT_OFS_INJ 8'h10
`define PLT_OFS_BITS_LO 8'h14
`define PLT_OFS_BITS_HI 8'h18
`define PLT_OFS_TXW 8'h1C
`define PLT_OFS_RXW 8'h20
`define PLT_OFS_CYC 8'h24
`define PLT_OFS_IRQ_STAT 8'h28
`define PLT_OFS_IRQ_MASK 8'h2C
`define PLT_OFS_CH_BASE 8'h40

// control register bit positions (write pulses)
`define PLT_CTRL_START 0
`define PLT_CTRL_STOP 1
`define PLT_CTRL_CLEAR 2
`define PLT_CTRL_INSERT 3

// config register fields
`define PLT_CFG_PAT_LSB 0
`define PLT_CFG_PORT 4
`define PLT_CFG_LOOP_LSB 8
`define PLT_CFG_RST 32'h00000003

// status register fields
`define PLT_STAT_RUN 0
`define PLT_STAT_SYNC_LSB 8
`define PLT_STAT_LOCK_LSB 16

// interrupt event bits
`define PLT_IRQ_SYNC 0
`define PLT_IRQ_ERR 1
`define PLT_IRQ_UNLOCK 2
`define PLT_IRQ_W 3

// pattern codes
`define PLT_PAT_PRBS7 3'h0
`define PLT_PAT_PRBS15 3'h1
`define PLT_PAT_PRBS23 3'h2
`define PLT_PAT_PRBS31 3'h3
`define PLT_PAT_HIGHF 3'h4
`define PLT_PAT_LOWF 3'h5

// pattern and checker constants
`define PLT_LOW_PERIOD 6'h21
`define PLT_LOW_HIGH 6'h11
`define PLT_SEED 31'h7FFFFFFF
`define PLT_UNSYNC_BITS 8'h08

`endif

// ===== rtl/plt_lane.v
// one lane: generator and checker
`timescale 1ns/1ps
`default_nettype none
`include "plt_consts.vh"
module plt_lane #(
   parameter W = 32
) (
   input wire sys_clk_i,
   input wire reset_n_i,
   input wire run_i,
   input wire start_i,
   input wire clear_i,
   input wire [2:0] pattern_i,
   input wire inject_i,
   input wire tx_ready_i,
   output wire [W-1:0] tx_data_o,
   output reg inj_done_o,
   input wire rx_valid_i,
   input wire [W-1:0] rx_data_i,
   output wire synced_o,
   output reg [7:0] err_bits_o,
   output reg checked_o,
   output wire [31:0] err_cnt_o
);
   reg [30:0] gen_st_q; // lfsr state, newest bit in bit 0
   reg [5:0] gen_ph_q; // low_freq bit phase 0..32
   reg [W-1:0] tx_q; // word on the wire
   reg inj_pend_q; // insert request waiting for a word
   reg [W-1:0] rx_prev_q; // last received word
   reg rx_msb_q; // last bit of the word before it
   reg [1:0] hist_q; // words of history held
   reg sync_q;
   reg [31:0] err_cnt_q;
   reg [W+30:0] gen_nx;
   reg [W+5:0] low_nx;
   reg [W-1:0] pred;
   reg [W+30:0] pred_nx; // {state, word} of the prediction
   reg [30:0] seed;
   reg [7:0] ecount;
   integer j;

   // feedback taps
   function tap;
      input [30:0] s;
      input [2:0] pat;
      begin
         case (pat)
            `PLT_PAT_PRBS7: tap = s[6] ^ s[5];
            `PLT_PAT_PRBS15: tap = s[14] ^ s[13];
            `PLT_PAT_PRBS23: tap = s[22] ^ s[17];
            default: tap = s[30] ^ s[27];
         endcase
      end
   endfunction

   // W bits of the sequence, first bit in bit 0; returns {state, word}
   function [W+30:0] prbs_step;
      input [30:0] st;
      input [2:0] pat;
      reg [30:0] s;
      reg [W-1:0] w;
      reg fb;
      integer i;
      begin
         s = st;
         w = {W{1'b0}};
         for (i = 0; i < W; i = i + 1) begin
            fb = tap(s, pat);
            w[i] = fb;
            s = {s[29:0], fb};
         end
         prbs_step = {s, w};
      end
   endfunction

   // low_freq square, 17 high 16 low; {phase, word}
   function [W+5:0] low_step;
      input [5:0] ph;
      reg [5:0] p;
      reg [W-1:0] w;
      integer i;
      begin
         p = ph;
         w = {W{1'b0}};
         for (i = 0; i < W; i = i + 1) begin
            w[i] = (p < `PLT_LOW_HIGH);
            p = (p == `PLT_LOW_PERIOD - 6'h01) ? 6'h00 : p + 6'h01;
         end
         low_step = {p, w};
      end
   endfunction

   // set bits in a word
   function [7:0] popcount;
      input [W-1:0] v;
      integer i;
      begin
         popcount = 8'h00;
         for (i = 0; i < W; i = i + 1) begin
            popcount = popcount + {7'h00, v[i]};
         end
      end
   endfunction

   // next word and prediction
   always @* begin
      gen_nx = prbs_step(gen_st_q, pattern_i);
      low_nx = low_step(gen_ph_q);
      seed = 31'h00000000;
      for (j = 0; j < 31; j = j + 1) begin
         seed[j] = rx_prev_q[W-1-j];
      end
      pred_nx = prbs_step(seed, pattern_i); // self-seeded, so no alignment needed
      if (pattern_i == `PLT_PAT_HIGHF) begin
         pred = rx_prev_q; // repeats word to word
      end else if (pattern_i == `PLT_PAT_LOWF) begin
         pred = {rx_prev_q[W-2:0], rx_msb_q}; // bit k equals bit k-33, W=32 only
      end else begin
         pred = pred_nx[W-1:0];
      end
      ecount = popcount(rx_data_i ^ pred);
   end

   // generator, one word per accepted transfer
   always @(posedge sys_clk_i) begin
      inj_done_o <= 1'b0;
      if (!reset_n_i) begin
         gen_st_q <= `PLT_SEED;
         gen_ph_q <= 6'h00;
         tx_q <= {W{1'b0}};
         inj_pend_q <= 1'b0;
      end else if (start_i) begin
         gen_st_q <= `PLT_SEED; // see R11
         gen_ph_q <= 6'h00;
         tx_q <= {W{1'b0}};
         inj_pend_q <= 1'b0;
      end else if (!run_i) begin
         tx_q <= {W{1'b0}}; // see R12
         inj_pend_q <= 1'b0;
      end else if (tx_ready_i) begin
         gen_st_q <= gen_nx[W+30:W];
         gen_ph_q <= low_nx[W+5:W];
         case (pattern_i)
            `PLT_PAT_HIGHF: tx_q <= {(W/2){2'b10}}; // see R3
            `PLT_PAT_LOWF: tx_q <= low_nx[W-1:0]; // see R4
            default: tx_q <= gen_nx[W-1:0]; // see R1 R2
         endcase
         if (inj_pend_q || inject_i) begin
            tx_q[0] <= ~((pattern_i == `PLT_PAT_HIGHF) ? 1'b0 :
               (pattern_i == `PLT_PAT_LOWF) ? low_nx[0] : gen_nx[0]); // see R6
            inj_done_o <= 1'b1;
         end
         inj_pend_q <= 1'b0;
      end else if (inject_i) begin
         inj_pend_q <= 1'b1; // held until the next word leaves
      end
   end

   // checker
   always @(posedge sys_clk_i) begin
      err_bits_o <= 8'h00;
      checked_o <= 1'b0;
      if (!reset_n_i || start_i) begin
         rx_prev_q <= {W{1'b0}};
         rx_msb_q <= 1'b0;
         hist_q <= 2'h0;
         sync_q <= 1'b0;
      end else if (run_i && rx_valid_i) begin
         rx_prev_q <= rx_data_i;
         rx_msb_q <= rx_prev_q[W-1];
         if (hist_q != 2'h2) begin
            hist_q <= hist_q + 2'h1;
         end else if (!sync_q) begin
            // all-zero words also satisfy an lfsr prediction, so refuse them
            sync_q <= (ecount == 8'h00) && (rx_data_i != {W{1'b0}}); // see R5
         end else begin
            err_bits_o <= ecount; // see R8
            checked_o <= 1'b1; // see R18
            if (ecount >= `PLT_UNSYNC_BITS) begin
               sync_q <= 1'b0; // see R5
            end
         end
      end
   end

   // per-channel error count, saturating
   always @(posedge sys_clk_i) begin
      if (!reset_n_i || clear_i) begin
         err_cnt_q <= 32'h00000000;
      end else if (err_bits_o != 8'h00) begin
         err_cnt_q <= (err_cnt_q > 32'hFFFFFFFF - {24'h000000, err_bits_o}) ? 32'hFFFFFFFF :
            err_cnt_q + {24'h000000, err_bits_o}; // see R13
      end
   end

   assign tx_data_o = tx_q;
   assign synced_o = sync_q;
   assign err_cnt_o = err_cnt_q;
endmodule
`default_nettype wire

// ===== rtl/plt_top.v
// loopback pattern tester top
// Function
// R1: generate and check prbs7, prbs15, prbs23
// R2: generate and check prbs31 as well
// R3: high_freq sends 1010, half bit rate
// R4: low_freq sends square at bit rate/33
// R5: per-channel sync flag on sequence start
// R6: each insert corrupts exactly one word
// R7: inserts ignored unless test running
// R8: count detected data errors, readable
// R9: count injected errors, readable
// R10: clear zeroes detected and injected counters
// R11: start begins generation and checking
// R12: stop halts generation and checking
// R13: per-channel lock, sync, error count
// R14: host selects which port is exercised
// R15: serial loopback routes tx into rx
// R16: tx and rx throughput counts for host
// R17: host clears before each start
// R18: count bits checked for error rate
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "plt_consts.vh"
module plt_top #(
   parameter NCH = 4,
   parameter W = 32
) (
   input wire sys_clk_i,
   input wire reset_n_i,
   input wire [7:0] bus_addr_i,
   input wire [31:0] bus_wdata_i,
   input wire bus_wr_i,
   input wire bus_rd_i,
   output reg [31:0] bus_rdata_o,
   output wire irq_o,
   input wire [NCH-1:0] pll_locked_i,
   input wire [NCH-1:0] tx_ready_i,
   output reg [NCH*W-1:0] tx_a_data_o,
   output reg [NCH*W-1:0] tx_b_data_o,
   input wire [NCH-1:0] rx_a_valid_i,
   input wire [NCH*W-1:0] rx_a_data_i,
   input wire [NCH-1:0] rx_b_valid_i,
   input wire [NCH*W-1:0] rx_b_data_i
);
   reg run_q; // test running
   reg start_q; // one-cycle start pulse to channels
   reg clear_q; // one-cycle clear pulse
   reg ins_q; // accepted insert request
   reg [31:0] cfg_q; // pattern, port, loopback mask
   reg [31:0] det_q; // detected errors, all channels
   reg [31:0] inj_q; // injected errors
   reg [63:0] bits_q; // bits compared
   reg [31:0] txw_q; // words sent during the run
   reg [31:0] rxw_q; // words checked during the run
   reg [31:0] cyc_q; // cycles of the run
   reg [`PLT_IRQ_W-1:0] irq_stat_q; // sticky events
   reg [`PLT_IRQ_W-1:0] irq_mask_q; // 1 lets an event through
   reg all_sync_q; // previous all-synced level
   reg [NCH-1:0] lock_q; // previous lock levels
   wire [NCH*W-1:0] tx_all; // generator words
   wire [NCH-1:0] inj_done;
   wire [NCH-1:0] synced;
   wire [NCH*8-1:0] err_bits;
   wire [NCH-1:0] checked;
   wire [NCH*32-1:0] ch_err;
   reg [NCH*W-1:0] rx_sel; // selected rx words
   reg [NCH-1:0] rxv_sel;
   reg [31:0] err_sum; // errors this cycle, all channels
   reg [31:0] inj_sum;
   reg [31:0] txw_sum;
   reg [31:0] rxw_sum;
   reg [31:0] rd_d; // next read data
   reg [`PLT_IRQ_W-1:0] irq_ev; // events seen this cycle
   wire [2:0] pattern = cfg_q[`PLT_CFG_PAT_LSB+2:`PLT_CFG_PAT_LSB];
   wire port_b = cfg_q[`PLT_CFG_PORT];
   wire [NCH-1:0] loop_en = cfg_q[`PLT_CFG_LOOP_LSB+NCH-1:`PLT_CFG_LOOP_LSB];
   wire wr_ctrl = bus_wr_i && (bus_addr_i == `PLT_OFS_CTRL);
   integer c;

   // register offset match
   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   // run control; stop wins over start
   always @(posedge sys_clk_i) begin
      start_q <= 1'b0;
      clear_q <= 1'b0;
      ins_q <= 1'b0;
      if (!reset_n_i) begin
         run_q <= 1'b0;
      end else if (wr_ctrl) begin
         if (bus_wdata_i[`PLT_CTRL_STOP]) begin
            run_q <= 1'b0; // see R12
         end else if (bus_wdata_i[`PLT_CTRL_START]) begin
            run_q <= 1'b1; // see R11
            start_q <= 1'b1;
         end
         clear_q <= bus_wdata_i[`PLT_CTRL_CLEAR]; // see R10
         // ignored outside a run
         ins_q <= bus_wdata_i[`PLT_CTRL_INSERT] && run_q &&
            !bus_wdata_i[`PLT_CTRL_STOP]; // see R7
      end
   end

   // config and mask writes
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         cfg_q <= `PLT_CFG_RST;
         irq_mask_q <= {`PLT_IRQ_W{1'b0}};
      end else if (bus_wr_i) begin
         if (hit(bus_addr_i, `PLT_OFS_CFG)) begin
            cfg_q <= bus_wdata_i; // see R1 R2 R14 R15
         end
         if (hit(bus_addr_i, `PLT_OFS_IRQ_MASK)) begin
            irq_mask_q <= bus_wdata_i[`PLT_IRQ_W-1:0];
         end
      end
   end

   // channels: the insert goes to channel 0 only, so one request is one word
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : ch
         plt_lane #(
            .W(W)
         ) u_lane (
            .sys_clk_i(sys_clk_i),
            .reset_n_i(reset_n_i),
            .run_i(run_q),
            .start_i(start_q),
            .clear_i(clear_q),
            .pattern_i(pattern),
            .inject_i((g == 0) ? ins_q : 1'b0), // see R6
            .tx_ready_i(tx_ready_i[g]),
            .tx_data_o(tx_all[g*W +: W]),
            .inj_done_o(inj_done[g]),
            .rx_valid_i(rxv_sel[g]),
            .rx_data_i(rx_sel[g*W +: W]),
            .synced_o(synced[g]),
            .err_bits_o(err_bits[g*8 +: 8]),
            .checked_o(checked[g]),
            .err_cnt_o(ch_err[g*32 +: 32])
         );
      end
   endgenerate

   // receive mux with loopback
   always @* begin
      rx_sel = port_b ? rx_b_data_i : rx_a_data_i; // see R14
      rxv_sel = port_b ? rx_b_valid_i : rx_a_valid_i;
      for (c = 0; c < NCH; c = c + 1) begin
         if (loop_en[c]) begin
            rx_sel[c*W +: W] = tx_all[c*W +: W]; // see R15
            rxv_sel[c] = tx_ready_i[c];
         end
      end
   end

   // transmit outputs per port
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         tx_a_data_o <= {NCH*W{1'b0}};
         tx_b_data_o <= {NCH*W{1'b0}};
      end else begin
         tx_a_data_o <= port_b ? {NCH*W{1'b0}} : tx_all; // see R14
         tx_b_data_o <= port_b ? tx_all : {NCH*W{1'b0}};
      end
   end

   // per-cycle totals
   always @* begin
      err_sum = 32'h00000000;
      inj_sum = 32'h00000000;
      txw_sum = 32'h00000000;
      rxw_sum = 32'h00000000;
      for (c = 0; c < NCH; c = c + 1) begin
         err_sum = err_sum + {24'h000000, err_bits[c*8 +: 8]};
         inj_sum = inj_sum + {31'h00000000, inj_done[c]};
         txw_sum = txw_sum + {31'h00000000, tx_ready_i[c] & run_q};
         rxw_sum = rxw_sum + {31'h00000000, checked[c]};
      end
   end

   // error counters, wrapping, cleared by clear only
   always @(posedge sys_clk_i) begin
      if (!reset_n_i || clear_q) begin
         det_q <= 32'h00000000; // see R10
         inj_q <= 32'h00000000;
      end else begin
         det_q <= det_q + err_sum; // see R8
         inj_q <= inj_q + inj_sum; // see R9
      end
   end

   // throughput counters restart with each run so rates cover that run only
   always @(posedge sys_clk_i) begin
      if (!reset_n_i || start_q) begin
         bits_q <= 64'h0000000000000000;
         txw_q <= 32'h00000000;
         rxw_q <= 32'h00000000;
         cyc_q <= 32'h00000000;
      end else if (run_q) begin
         bits_q <= bits_q + rxw_sum * W; // see R18
         txw_q <= txw_q + txw_sum; // see R16
         rxw_q <= rxw_q + rxw_sum; // see R16
         cyc_q <= cyc_q + 32'h00000001;
      end
   end

   // interrupt events
   always @* begin
      irq_ev = {`PLT_IRQ_W{1'b0}};
      irq_ev[`PLT_IRQ_SYNC] = (&synced) && !all_sync_q;
      irq_ev[`PLT_IRQ_ERR] = (err_sum != 32'h00000000);
      irq_ev[`PLT_IRQ_UNLOCK] = |(lock_q & ~pll_locked_i);
   end

   // sticky status: write one to clear, a new event in the same cycle wins
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         irq_stat_q <= {`PLT_IRQ_W{1'b0}};
         all_sync_q <= 1'b0;
         lock_q <= {NCH{1'b0}};
      end else begin
         all_sync_q <= &synced;
         lock_q <= pll_locked_i;
         if (bus_wr_i && hit(bus_addr_i, `PLT_OFS_IRQ_STAT)) begin
            irq_stat_q <= (irq_stat_q & ~bus_wdata_i[`PLT_IRQ_W-1:0]) | irq_ev;
         end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
         end
      end
   end

   assign irq_o = |(irq_stat_q & irq_mask_q);

   // read decode; unmapped offsets read as zero
   always @* begin
      rd_d = 32'h00000000;
      case (bus_addr_i)
         `PLT_OFS_CTRL: rd_d[`PLT_STAT_RUN] = run_q;
         `PLT_OFS_CFG: rd_d = cfg_q;
         `PLT_OFS_STAT: begin
            rd_d[`PLT_STAT_RUN] = run_q;
            rd_d[`PLT_STAT_SYNC_LSB+NCH-1:`PLT_STAT_SYNC_LSB] = synced; // see R5 R13
            rd_d[`PLT_STAT_LOCK_LSB+NCH-1:`PLT_STAT_LOCK_LSB] = pll_locked_i; // see R13
         end
         `PLT_OFS_DET: rd_d = det_q;
         `PLT_OFS_INJ: rd_d = inj_q;
         `PLT_OFS_BITS_LO: rd_d = bits_q[31:0];
         `PLT_OFS_BITS_HI: rd_d = bits_q[63:32];
         `PLT_OFS_TXW: rd_d = txw_q;
         `PLT_OFS_RXW: rd_d = rxw_q;
         `PLT_OFS_CYC: rd_d = cyc_q;
         `PLT_OFS_IRQ_STAT: rd_d[`PLT_IRQ_W-1:0] = irq_stat_q;
         `PLT_OFS_IRQ_MASK: rd_d[`PLT_IRQ_W-1:0] = irq_mask_q;
         default: begin
            for (c = 0; c < NCH; c = c + 1) begin
               if (hit(bus_addr_i, `PLT_OFS_CH_BASE + c[5:0] * 8'h04)) begin
                  rd_d = ch_err[c*32 +: 32]; // see R13
               end
            end
         end
      endcase
   end

   // read data stands one cycle
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         bus_rdata_o <= 32'h00000000;
      end else begin
         bus_rdata_o <= bus_rd_i ? rd_d : 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// ===== sim/plt_mon_monitor.sv
// port checker for the pattern tester
`timescale 1ns/1ps
`default_nettype none
`include "plt_consts.vh"
module plt_mon #(
   parameter NCH = 4,
   parameter W = 32
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic [7:0] bus_addr_i,
   input wire logic [31:0] bus_wdata_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic [31:0] bus_rdata_o,
   input wire logic irq_o,
   input wire logic [NCH-1:0] tx_ready_i,
   input wire logic [NCH*W-1:0] tx_a_data_o,
   input wire logic [NCH*W-1:0] tx_b_data_o
);
   logic run_q; // shadow of the run state
   logic [11:0] cfg_q; // config shadow
   logic [2:0] mask_q; // shadow of the irq mask
   logic [1:0] quiet_q; // cycles since a write
   wire unmapped = (bus_addr_i[1:0] != 2'h0) || (bus_addr_i > `PLT_OFS_IRQ_MASK && bus_addr_i < `PLT_OFS_CH_BASE)
      || (bus_addr_i >= `PLT_OFS_CH_BASE + 4 * NCH); // holes of the map
   // shadows follow host writes only
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         run_q <= 1'b0;
         cfg_q <= 12'h003;
         mask_q <= 3'h0;
         quiet_q <= 2'h0;
      end else begin
         if (bus_wr_i) quiet_q <= 2'h0;
         else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
         if (bus_wr_i && bus_addr_i == `PLT_OFS_CTRL && bus_wdata_i[`PLT_CTRL_STOP]) run_q <= 1'b0;
         else if (bus_wr_i && bus_addr_i == `PLT_OFS_CTRL && bus_wdata_i[`PLT_CTRL_START]) run_q <= 1'b1;
         if (bus_wr_i && bus_addr_i == `PLT_OFS_CFG) cfg_q <= bus_wdata_i[11:0] & 12'hF17;
         if (bus_wr_i && bus_addr_i == `PLT_OFS_IRQ_MASK) mask_q <= bus_wdata_i[2:0];
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence rd_at(logic [7:0] a);
      bus_rd_i && bus_addr_i == a;
   endsequence
   rdata_idle_a: assert property (!$past(bus_rd_i) |-> bus_rdata_o == 32'h0)
      else $error("idle read data");
   run_read_a: assert property ((rd_at(`PLT_OFS_CTRL) or rd_at(`PLT_OFS_STAT)) |=> bus_rdata_o[0] == $past(run_q))
      else $error("run bit");
   cfg_read_a: assert property (rd_at(`PLT_OFS_CFG) |=> (bus_rdata_o[11:0] & 12'hF17) == $past(cfg_q))
      else $error("config");
   hole_read_a: assert property (bus_rd_i && unmapped |=> bus_rdata_o == 32'h0)
      else $error("hole read");
   stop_idle_a: assert property (!run_q && quiet_q == 2'h3 |-> tx_a_data_o == '0 && tx_b_data_o == '0)
      else $error("tx while stopped");
   port_sel_a: assert property (cfg_q[4] && quiet_q == 2'h3 |-> tx_a_data_o == '0)
      else $error("port A driven");
   port_unsel_a: assert property (!cfg_q[4] && quiet_q == 2'h3 |-> tx_b_data_o == '0)
      else $error("port B driven");
   word_hold_a: assert property (run_q && quiet_q == 2'h3 && !$past(tx_ready_i[0]) && !$past(tx_ready_i[0], 2)
      |-> $stable(tx_a_data_o[W-1:0]))
      else $error("word moved");
   irq_mask_a: assert property (mask_q == 3'h0 |-> !irq_o)
      else $error("irq while masked");
   reset_out_a: assert property ($rose(reset_n_i) |-> !irq_o && tx_a_data_o == '0 && bus_rdata_o == 32'h0)
      else $error("reset outputs");
endmodule
`default_nettype wire

// ===== sim/plt_loop_model.sv
// loopback path model
`timescale 1ns/1ps
`default_nettype none
module plt_loop_model #(
   parameter NCH = 4,
   parameter W = 32
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic cut_i,
   input wire logic stall_i,
   input wire logic [NCH*W-1:0] tx_a_data_i,
   input wire logic [NCH*W-1:0] tx_b_data_i,
   output logic [NCH-1:0] tx_ready_o,
   output logic [NCH-1:0] rx_a_valid_o,
   output logic [NCH-1:0] rx_b_valid_o,
   output logic [NCH*W-1:0] rx_a_data_o,
   output logic [NCH*W-1:0] rx_b_data_o
);
   logic [1:0] ph_q; // stall phase
   logic [NCH-1:0] v1_q; // ready one edge old
   logic [NCH-1:0] v2_q; // ready two edges old
   logic [NCH*W-1:0] noise_q; // cut path noise
   // ready pacing, valid pipeline and noise
   always @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         ph_q <= 2'h0;
         v1_q <= '0;
         v2_q <= '0;
         noise_q <= '0;
         tx_ready_o <= '0;
      end else begin
         ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
         tx_ready_o <= (stall_i && ph_q != 2'h0) ? '0 : '1;
         v1_q <= tx_ready_o;
         v2_q <= v1_q;
         noise_q <= noise_q + {NCH*W/8{8'h35}};
      end
   end
   // a cut path still claims valid data, so the checker must not sync on noise
   assign rx_a_valid_o = v2_q;
   assign rx_b_valid_o = v2_q;
   assign rx_a_data_o = cut_i ? noise_q : tx_a_data_i;
   assign rx_b_data_o = cut_i ? noise_q : tx_b_data_i;
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// bench for the pattern tester
`timescale 1ns/1ps
`default_nettype none
`include "plt_consts.vh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_fail++; \
   $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
   localparam int NCH = 4;
   localparam int W = 32;
   logic sys_clk_i, reset_n_i, bus_wr_i, bus_rd_i, cut, stall;
   logic [7:0] bus_addr_i;
   logic [31:0] bus_wdata_i, t, r, b;
   logic [NCH-1:0] pll_locked_i;
   wire [31:0] bus_rdata_o;
   wire irq_o;
   wire [NCH-1:0] tx_ready, rx_a_valid, rx_b_valid;
   wire [NCH*W-1:0] tx_a_data_o, tx_b_data_o, rx_a_data, rx_b_data;
   int n_fail, checks_done, ones;
   localparam logic [31:0] ALL = 32'hFFFFFFFF;
   plt_top #(.NCH(NCH), .W(W)) i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .bus_addr_i(bus_addr_i),
      .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .irq_o(irq_o),
      .pll_locked_i(pll_locked_i), .tx_ready_i(tx_ready), .tx_a_data_o(tx_a_data_o), .tx_b_data_o(tx_b_data_o),
      .rx_a_valid_i(rx_a_valid), .rx_a_data_i(rx_a_data), .rx_b_valid_i(rx_b_valid), .rx_b_data_i(rx_b_data));
   plt_loop_model #(.NCH(NCH), .W(W)) i_loop (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .cut_i(cut),
      .stall_i(stall), .tx_a_data_i(tx_a_data_o), .tx_b_data_i(tx_b_data_o), .tx_ready_o(tx_ready),
      .rx_a_valid_o(rx_a_valid), .rx_b_valid_o(rx_b_valid), .rx_a_data_o(rx_a_data), .rx_b_data_o(rx_b_data));
   // clock
   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   // write, then one idle cycle
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus_addr_i <= a;
      bus_wdata_i <= d;
      bus_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      bus_wr_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   // read; data stand in the next cycle
   task rd(input logic [7:0] a, output logic [31:0] d);
      bus_addr_i <= a;
      bus_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      bus_rd_i <= 1'b0;
      @(posedge sys_clk_i);
      d = bus_rdata_o;
   endtask
   task chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      `CHK($sformatf("reg %0h", a), e, v & m)
   endtask
   // bounded poll; timeout ends the run
   task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input int n);
      logic [31:0] v;
      for (int i = 0; i < n; i++) begin
         rd(a, v);
         if ((v & m) === e) break;
      end
      `CHK($sformatf("poll %0h", a), e, v & m)
      if ((v & m) !== e) print_verdict();
   endtask
   task ctl(input int b);
      wr(`PLT_OFS_CTRL, 32'h1 << b);
   endtask
   // clear, configure, start, await sync; start has already dropped the old sync before the extra edge
   task go(input logic [31:0] cfg);
      ctl(`PLT_CTRL_CLEAR);
      wr(`PLT_OFS_CFG, cfg);
      ctl(`PLT_CTRL_START);
      @(posedge sys_clk_i);
      poll(`PLT_OFS_STAT, 32'h00000F01, 32'h00000F01, 300);
   endtask
   task halt;
      ctl(`PLT_CTRL_STOP);
      chk_rd(`PLT_OFS_STAT, 32'h00000001, 32'h00000000);
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      n_fail = 0;
      checks_done = 0;
      reset_n_i = 1'b0;
      bus_addr_i = 8'h00;
      bus_wdata_i = 32'h00000000;
      bus_wr_i = 1'b0;
      bus_rd_i = 1'b0;
      pll_locked_i = 4'hF;
      cut = 1'b0;
      stall = 1'b0;
      repeat (6) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      @(posedge sys_clk_i);
      chk_rd(`PLT_OFS_CFG, 32'h00000F17, `PLT_CFG_RST);
      chk_rd(8'hFC, ALL, 32'h00000000);
      chk_rd(`PLT_OFS_STAT, ALL, 32'h000F0000);
      // each pattern
      for (int p = 0; p <= 5; p++) begin
         go(p);
         if (p == 4) `CHK("high word", {16{2'b10}}, tx_a_data_o[W-1:0])
         if (p == 5) begin
            ones = 0;
            repeat (33) begin
               @(posedge sys_clk_i);
               ones += $countones(tx_a_data_o[W-1:0]);
            end
            `CHK("low ones", 544, ones)
         end
         chk_rd(`PLT_OFS_DET, ALL, 32'h00000000);
         halt();
      end
      ctl(`PLT_CTRL_INSERT);
      chk_rd(`PLT_OFS_INJ, ALL, 32'h00000000);
      // inserts and error irq; a bit-0 flip costs one bit with prbs31
      wr(`PLT_OFS_IRQ_STAT, 32'h00000007);
      wr(`PLT_OFS_IRQ_MASK, 32'h1 << `PLT_IRQ_ERR);
      go(`PLT_PAT_PRBS31);
      `CHK("irq idle", 1'b0, irq_o)
      ctl(`PLT_CTRL_INSERT);
      poll(`PLT_OFS_INJ, ALL, 32'h00000001, 20);
      poll(`PLT_OFS_DET, ALL, 32'h00000001, 20);
      chk_rd(`PLT_OFS_DET, ALL, 32'h00000001);
      `CHK("irq err", 1'b1, irq_o)
      chk_rd(`PLT_OFS_CH_BASE, ALL, 32'h00000001);
      chk_rd(`PLT_OFS_CH_BASE + 8'h04, ALL, 32'h00000000);
      wr(`PLT_OFS_IRQ_STAT, 32'h1 << `PLT_IRQ_ERR);
      `CHK("irq cleared", 1'b0, irq_o)
      ctl(`PLT_CTRL_INSERT);
      poll(`PLT_OFS_INJ, ALL, 32'h00000002, 20);
      poll(`PLT_OFS_DET, ALL, 32'h00000002, 20);
      ctl(`PLT_CTRL_CLEAR);
      poll(`PLT_OFS_DET, ALL, 32'h00000000, 4);
      chk_rd(`PLT_OFS_INJ, ALL, 32'h00000000);
      chk_rd(`PLT_OFS_CH_BASE, ALL, 32'h00000000);
      halt();
      // throughput after stop
      rd(`PLT_OFS_TXW, t);
      rd(`PLT_OFS_RXW, r);
      rd(`PLT_OFS_BITS_LO, b);
      `CHK("tx words", 1'b1, t != 32'h0)
      `CHK("rx words", 1'b1, r != 32'h0)
      `CHK("bits checked", r * W, b)
      // lock loss
      wr(`PLT_OFS_IRQ_MASK, 32'h1 << `PLT_IRQ_UNLOCK);
      pll_locked_i <= 4'hD;
      poll(`PLT_OFS_STAT, 32'h000F0000, 32'h000D0000, 10);
      `CHK("irq unlock", 1'b1, irq_o)
      pll_locked_i <= 4'hF;
      wr(`PLT_OFS_IRQ_STAT, 32'h1 << `PLT_IRQ_UNLOCK);
      `CHK("irq unlock cleared", 1'b0, irq_o)
      wr(`PLT_OFS_IRQ_MASK, 32'h00000000);
      // port B, stalling
      go(32'h00000013);
      `CHK("port a idle", {NCH*W{1'b0}}, tx_a_data_o)
      `CHK("port b busy", 1'b1, tx_b_data_o != '0)
      stall <= 1'b1;
      repeat (4) chk_rd(`PLT_OFS_STAT, 32'h00000001, 32'h00000001);
      stall <= 1'b0;
      halt();
      // cut path, internal loopback
      cut <= 1'b1;
      go(32'h00000F03);
      halt();
      cut <= 1'b0;
      // mid-run reset
      go(`PLT_PAT_PRBS7);
      reset_n_i <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      @(posedge sys_clk_i);
      chk_rd(`PLT_OFS_CFG, 32'h00000F17, `PLT_CFG_RST);
      chk_rd(`PLT_OFS_STAT, 32'h00000F01, 32'h00000000);
      print_verdict();
   end
endmodule
bind plt_top plt_mon #(.NCH(NCH), .W(W)) i_mon (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
   .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
   .bus_rdata_o(bus_rdata_o), .irq_o(irq_o), .tx_ready_i(tx_ready_i), .tx_a_data_o(tx_a_data_o),
   .tx_b_data_o(tx_b_data_o));
`default_nettype wire
